/* File: pkg/sesp_pkg.sv */
package sesp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_NS     = 5;
  localparam int WR_TIME_US_DEF = 5000;
  localparam int BUSY_CNT_W     = 24;

  // ----------------------------------------------------------------
  // memory geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 15;
  localparam int          MEM_DEPTH   = 32768;
  localparam int          PAGE_BYTES  = 64;
  localparam int          PAGE_W      = 6;
  localparam int          ROW_LSB     = 6;
  localparam logic [14:0] MASK_LARGE  = 15'h7fff;
  localparam logic [14:0] MASK_SMALL  = 15'h3fff;
  localparam logic [6:0]  COMMIT_END  = 7'h40;

  // ----------------------------------------------------------------
  // select byte layout and bit slots
  // ----------------------------------------------------------------
  localparam int         SEL_TYPE_MSB = 7;
  localparam int         SEL_TYPE_LSB = 4;
  localparam int         SEL_CE_MSB   = 3;
  localparam int         SEL_CE_LSB   = 1;
  localparam int         SEL_RW_BIT   = 0;
  localparam logic [2:0] CHIP_EN_CODE = 3'h0;
  localparam logic       RW_READ      = 1'b1;
  localparam logic [3:0] BIT_FIRST    = 4'h1;
  localparam logic [3:0] BIT_LAST     = 4'h7;
  localparam logic [3:0] BIT_ACK      = 4'h8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SEL    = 3'b001,
    ST_AHI    = 3'b010,
    ST_ALO    = 3'b011,
    ST_WDATA  = 3'b100,
    ST_RDATA  = 3'b101,
    ST_NACKED = 3'b110,
    ST_BUSY   = 3'b111
  } sesp_state_t;

  // bus events seen in the system clock domain
  typedef struct packed {
    logic start;
    logic stop;
    logic fall;
    logic rise;
    logic bit_val;
  } sesp_ev_t;

endpackage : sesp_pkg

/* File: rtl/sesp_eeprom.sv */
`timescale 1ns/1ps
// Overview of operation
// - select code: type field, chip enable zeros
// - eighth bit one reads, zero writes
// - matching select acknowledged in ninth bit
// - mismatch releases bus until next start
// - address sent high byte then low byte
// - top address bits ignored per variant
// - write acknowledges select and both address bytes
// - inhibit from start to address blocks write
// - byte write acked unless inhibited
// - page write holds 64 bytes of one row
// - page write increments low six bits only
// - write cycle starts only on tenth-slot stop
// - busy write cycle ignores all bus activity
// - after write cycle, poll select acknowledged
// - reads ignore the write inhibit input
// - random read: dummy write, restart, read select
// - current read outputs counter byte, increments counter
// - sequential read returns one or more bytes
// - start and stop are data edges, clock high
// - data sampled on rising serial clock edge
// - stop after master nack returns to standby
module sesp_eeprom
  import sesp_pkg::*;
#(
  parameter int         WR_TIME_US    = sesp_pkg::WR_TIME_US_DEF,
  // value is arbitrary, set to suit the system
  parameter logic [3:0] DEV_TYPE      = 4'h5,
  parameter logic       SMALL_VARIANT = 1'b0
) (
  // system clock and reset
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  // serial link
  input  wire logic scl_clk_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  // write protection and status
  input  wire logic write_inhibit_input_i,
  output logic      write_busy_o
);
  import sesp_pkg::*;

  localparam int WR_CYCLES = (WR_TIME_US * 1000 + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam logic [BUSY_CNT_W-1:0] BUSY_LAST = BUSY_CNT_W'(WR_CYCLES - 1);

  // ----------------------------------------------------------------
  // link clock domain
  // ----------------------------------------------------------------
  logic link_smp_ff;
  logic link_tgl_ff;

  always_ff @(posedge scl_clk_i or posedge reset_i) begin
    if (reset_i) begin
      link_smp_ff <= 1'b0;
      link_tgl_ff <= 1'b0;
    end else begin
      link_smp_ff <= sda_i;
      link_tgl_ff <= ~link_tgl_ff;
    end
  end

  // ----------------------------------------------------------------
  // synchronisers into the system domain
  // ----------------------------------------------------------------
  logic scl_m_ff, scl_s_ff, scl_q_ff;
  logic sda_m_ff, sda_s_ff, sda_q_ff;
  logic tgl_m_ff, tgl_s_ff, tgl_q_ff;
  logic wi_m_ff,  wi_s_ff;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      {scl_m_ff, scl_s_ff, scl_q_ff} <= 3'h7;
      {sda_m_ff, sda_s_ff, sda_q_ff} <= 3'h7;
      {tgl_m_ff, tgl_s_ff, tgl_q_ff} <= 3'h0;
      {wi_m_ff, wi_s_ff}             <= 2'h0;
    end else begin
      {scl_m_ff, scl_s_ff, scl_q_ff} <= {scl_clk_i, scl_m_ff, scl_s_ff};
      {sda_m_ff, sda_s_ff, sda_q_ff} <= {sda_i, sda_m_ff, sda_s_ff};
      {tgl_m_ff, tgl_s_ff, tgl_q_ff} <= {link_tgl_ff, tgl_m_ff, tgl_s_ff};
      {wi_m_ff, wi_s_ff}             <= {write_inhibit_input_i, wi_m_ff};
    end
  end

  // ----------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------
  sesp_ev_t ev;

  // edges of data while clock high
  assign ev.start   = scl_s_ff & scl_q_ff & sda_q_ff & ~sda_s_ff;
  assign ev.stop    = scl_s_ff & scl_q_ff & ~sda_q_ff & sda_s_ff;
  assign ev.fall    = scl_q_ff & ~scl_s_ff;
  // the sampled bit is held a whole clock phase, so the toggle qualifies it
  assign ev.rise    = tgl_s_ff ^ tgl_q_ff;
  assign ev.bit_val = link_smp_ff;

  // ----------------------------------------------------------------
  // protocol state
  // ----------------------------------------------------------------
  sesp_state_t           state_ff,    nxt_state;
  logic [3:0]            bitcnt_ff,   nxt_bitcnt;
  logic [7:0]            rx_ff,       nxt_rx;
  logic [7:0]            tx_ff,       nxt_tx;
  logic                  tx_en_ff,    nxt_tx_en;
  logic                  ack_ff,      nxt_ack;
  logic                  post_ack_ff, nxt_post_ack;
  logic                  inh_ff,      nxt_inh;
  logic                  drive_ff,    nxt_drive;
  logic [ADDR_W-1:0]     addr_ff,     nxt_addr;
  logic [BUSY_CNT_W-1:0] busy_cnt_ff, nxt_busy_cnt;
  logic [6:0]            commit_ff,   nxt_commit;
  logic [PAGE_BYTES-1:0] page_vld_ff;

  logic [7:0] mem     [MEM_DEPTH];
  logic [7:0] page_mem[PAGE_BYTES];

  wire [7:0]        rx_byte    = {rx_ff[6:0], ev.bit_val};
  wire [ADDR_W-1:0] addr_mask  = SMALL_VARIANT ? MASK_SMALL : MASK_LARGE;
  wire [ADDR_W-1:0] addr_inc   = (addr_ff + 15'h0001) & addr_mask;
  wire [PAGE_W-1:0] page_idx   = addr_ff[PAGE_W-1:0];
  wire [ADDR_W-1:0] page_inc   = {addr_ff[ADDR_W-1:ROW_LSB], page_idx + 6'h01};
  wire [7:0]        mem_rd     = mem[addr_ff];
  wire              in_frame   = (state_ff != ST_IDLE) && (state_ff != ST_BUSY);
  wire              inh_window = (state_ff == ST_SEL) || (state_ff == ST_AHI) || (state_ff == ST_ALO);
  wire              byte_done  = in_frame && ev.rise && (bitcnt_ff == BIT_LAST);
  wire              busy       = (state_ff == ST_BUSY);
  wire              busy_done  = busy && (busy_cnt_ff == BUSY_LAST);
  wire [2:0]        tx_sel     = BIT_LAST[2:0] - bitcnt_ff[2:0];
  wire              sel_match  = (rx_byte[SEL_TYPE_MSB:SEL_TYPE_LSB] == DEV_TYPE) &&
                                 (rx_byte[SEL_CE_MSB:SEL_CE_LSB] == CHIP_EN_CODE);
  wire              sel_read   = (rx_byte[SEL_RW_BIT] == RW_READ);
  wire              wr_trigger = ev.stop && (state_ff == ST_WDATA) && post_ack_ff &&
                                 (bitcnt_ff == BIT_FIRST) && (|page_vld_ff);
  // inhibited writes never reach the page latches
  wire              page_we    = byte_done && (state_ff == ST_WDATA) && !inh_ff;
  wire              commit_we  = busy && (commit_ff < COMMIT_END) && page_vld_ff[commit_ff[PAGE_W-1:0]];
  wire [ADDR_W-1:0] commit_adr = {addr_ff[ADDR_W-1:ROW_LSB], commit_ff[PAGE_W-1:0]};

  always_comb begin
    nxt_state    = state_ff;
    nxt_bitcnt   = bitcnt_ff;
    nxt_rx       = rx_ff;
    nxt_tx       = tx_ff;
    nxt_tx_en    = tx_en_ff;
    nxt_ack      = ack_ff;
    nxt_post_ack = post_ack_ff;
    nxt_inh      = inh_ff;
    nxt_addr     = addr_ff;
    nxt_busy_cnt = busy_cnt_ff;
    nxt_commit   = commit_ff;
    if (busy) begin
      nxt_busy_cnt = busy_cnt_ff + 24'h00_0001;
      if (commit_ff < COMMIT_END)
        nxt_commit = commit_ff + 7'h01;
      if (busy_done) begin
        nxt_state    = ST_IDLE;
        nxt_busy_cnt = '0;
        nxt_commit   = '0;
      end
    end else if (ev.start) begin
      nxt_state    = ST_SEL;
      nxt_bitcnt   = '0;
      nxt_tx_en    = 1'b0;
      nxt_ack      = 1'b0;
      nxt_post_ack = 1'b0;
      nxt_inh      = wi_s_ff;
    end else if (ev.stop) begin
      nxt_state    = wr_trigger ? ST_BUSY : ST_IDLE;
      nxt_tx_en    = 1'b0;
      nxt_ack      = 1'b0;
    end else begin
      if (inh_window)
        nxt_inh = inh_ff | wi_s_ff;
      if (ev.rise && in_frame) begin
        if (bitcnt_ff == BIT_ACK) begin
          nxt_bitcnt   = '0;
          nxt_post_ack = 1'b1;
          nxt_ack      = 1'b0;
          if (state_ff == ST_RDATA) begin
            // master ack keeps the read going
            if (ack_ff || !ev.bit_val) begin
              nxt_tx    = mem_rd;
              nxt_tx_en = 1'b1;
              nxt_addr  = addr_inc;
            end else begin
              nxt_tx_en = 1'b0;
              nxt_state = ST_NACKED;
            end
          end
        end else begin
          nxt_rx       = rx_byte;
          nxt_bitcnt   = bitcnt_ff + 4'h1;
          // the stop's own clock rise must not clear the tenth-slot mark
          nxt_post_ack = post_ack_ff && (nxt_bitcnt == BIT_FIRST);
          if (bitcnt_ff == BIT_LAST) begin
            unique case (state_ff)
              ST_SEL: begin
                nxt_ack   = sel_match;
                nxt_state = !sel_match ? ST_IDLE : (sel_read ? ST_RDATA : ST_AHI);
              end
              ST_AHI: begin
                nxt_ack  = 1'b1;
                nxt_addr  = {rx_byte[6:0], addr_ff[7:0]} & addr_mask;
                nxt_state = ST_ALO;
              end
              ST_ALO: begin
                nxt_ack   = 1'b1;
                nxt_addr  = {addr_ff[ADDR_W-1:8], rx_byte};
                nxt_state = ST_WDATA;
                nxt_inh   = inh_ff | wi_s_ff;
              end
              ST_WDATA: begin
                nxt_ack = !inh_ff;
                if (!inh_ff)
                  nxt_addr = page_inc;
              end
              ST_RDATA:  nxt_ack = 1'b0;
              ST_NACKED: nxt_ack = 1'b0;
            endcase
          end
        end
      end
    end
  end

  // read path never looks at inhibit
  always_comb begin
    nxt_drive = drive_ff;
    if (busy || !in_frame || ev.start || ev.stop)
      nxt_drive = 1'b0;
    else if (ev.fall)
      nxt_drive = (bitcnt_ff == BIT_ACK) ? ack_ff : (tx_en_ff & ~tx_ff[tx_sel]);
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff    <= ST_IDLE;
      bitcnt_ff   <= '0;
      rx_ff       <= '0;
      tx_ff       <= '0;
      tx_en_ff    <= 1'b0;
      ack_ff      <= 1'b0;
      post_ack_ff <= 1'b0;
      inh_ff      <= 1'b0;
      drive_ff    <= 1'b0;
      addr_ff     <= '0;
      busy_cnt_ff <= '0;
      commit_ff   <= '0;
    end else begin
      state_ff    <= nxt_state;
      bitcnt_ff   <= nxt_bitcnt;
      rx_ff       <= nxt_rx;
      tx_ff       <= nxt_tx;
      tx_en_ff    <= nxt_tx_en;
      ack_ff      <= nxt_ack;
      post_ack_ff <= nxt_post_ack;
      inh_ff      <= nxt_inh;
      drive_ff    <= nxt_drive;
      addr_ff     <= nxt_addr;
      busy_cnt_ff <= nxt_busy_cnt;
      commit_ff   <= nxt_commit;
    end
  end

  // ----------------------------------------------------------------
  // page latches and cell array
  // ----------------------------------------------------------------
  // one row per write cycle
  generate
    for (genvar i = 0; i < PAGE_BYTES; i++) begin : g_page
      wire hit = page_we && (page_idx == PAGE_W'(i));
      always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i)
          page_vld_ff[i] <= 1'b0;
        else if (hit)
          page_vld_ff[i] <= 1'b1;
        else if (busy_done || (ev.start && !busy))
          page_vld_ff[i] <= 1'b0;
      end
      always_ff @(posedge sys_clk_i) begin
        if (hit)
          page_mem[i] <= rx_byte;
      end
    end
  endgenerate

  // cells are only touched while busy, one latched byte per clock
  always_ff @(posedge sys_clk_i) begin
    if (commit_we)
      mem[commit_adr] <= page_mem[commit_ff[PAGE_W-1:0]];
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open drain, low only when driving
  assign sda_o        = 1'b0;
  assign sda_oe_o     = drive_ff;
  assign write_busy_o = busy;

endmodule : sesp_eeprom

/* File: verification/sesp_eeprom_checker.sv */
`timescale 1ns/1ps
module sesp_eeprom_checker
  import sesp_pkg::*;
#(
  parameter int WR_TIME_US = 1
) (
  // watched ports
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic scl_clk_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic write_inhibit_input_i,
  input wire logic write_busy_o
);
  // ----------------------------------------------------------------
  // write cycle length counter
  // ----------------------------------------------------------------
  localparam int WR_CYC = WR_TIME_US * 1000 / SYS_CLK_NS;
  int busy_cnt_ff;
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_cnt_ff <= 0;
    end else begin
      busy_cnt_ff <= write_busy_o ? busy_cnt_ff + 1 : 0;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_open_drain; sda_o == 1'b0; endproperty
  property p_busy_quiet; write_busy_o |-> !sda_oe_o; endproperty
  property p_busy_len; $fell(write_busy_o) |-> busy_cnt_ff == WR_CYC; endproperty
  property p_busy_on_stop; $rose(write_busy_o) |-> scl_clk_i && sda_i && !$past(sda_i, 6); endproperty
  property p_busy_inhibit; $rose(write_busy_o) |-> !write_inhibit_input_i; endproperty
  property p_oe_scl_low; $changed(sda_oe_o) |-> !scl_clk_i; endproperty
  property p_ack_hold; $rose(sda_oe_o) |=> sda_oe_o [*8]; endproperty
  property p_busy_hold; $rose(write_busy_o) |=> write_busy_o [*8]; endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data output value not low");
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("data line pulled during write cycle");
  a_busy_len: assert property (p_busy_len)
    else $error("write cycle length wrong");
  a_busy_on_stop: assert property (p_busy_on_stop)
    else $error("write cycle began without a stop");
  a_busy_inhibit: assert property (p_busy_inhibit)
    else $error("write cycle began while inhibited");
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data drive changed while serial clock high");
  a_ack_hold: assert property (p_ack_hold)
    else $error("data drive too short");
  a_busy_hold: assert property (p_busy_hold)
    else $error("write cycle dropped early");
  c_busy: cover property ($rose(write_busy_o));
  c_drive: cover property ($rose(sda_oe_o));
  c_done: cover property ($fell(write_busy_o));
endmodule : sesp_eeprom_checker

bind sesp_eeprom sesp_eeprom_checker #(.WR_TIME_US(WR_TIME_US)) i_chk (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .scl_clk_i(scl_clk_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .write_inhibit_input_i(write_inhibit_input_i), .write_busy_o(write_busy_o)
);

/* File: verification/sesp_master.sv */
`timescale 1ns/1ps
module sesp_master (
  // link clock and wire
  input  wire logic m_clk_i,
  input  wire logic line_i,
  output logic      scl_o,
  output logic      sda_o
);
  // ----------------------------------------------------------------
  // bus master steps; clock stands high outside frames
  // ----------------------------------------------------------------
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic step(input logic c, input logic d);
    scl_o = c;
    sda_o = d;
    @(posedge m_clk_i);
  endtask : step
  task automatic start();
    step(scl_o, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask : start
  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b1, 1'b1);
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    step(1'b0, b);
    step(1'b1, b);
    r = line_i;
    step(1'b1, b);
    step(1'b0, b);
  endtask : bit_io
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bit_io(1'b1, r);
      d = {d[6:0], r};
    end
    bit_io(nack, r);
  endtask : rbyte
endmodule : sesp_master

/* File: verification/tb.sv */
`timescale 1ns/1ps
module tb;
  import sesp_pkg::*;
  // ----------------------------------------------------------------
  // clocks, wire and device
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV = 4'h5;
  logic sys_clk_i = 1'b0;
  logic reset_i   = 1'b1;
  logic m_clk     = 1'b0;
  logic inhibit   = 1'b0;
  logic scl, m_sda, sda_o, sda_oe_o, busy;
  wire  line = m_sda & (sda_oe_o ? sda_o : 1'b1);
  int   n_errors = 0;
  int   compares = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  initial begin
    #13;
    forever #32 m_clk = ~m_clk;
  end
  sesp_eeprom #(.WR_TIME_US(1), .DEV_TYPE(DEV), .SMALL_VARIANT(1'b0)) i_dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .scl_clk_i(scl), .sda_i(line), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .write_inhibit_input_i(inhibit), .write_busy_o(busy));
  sesp_master i_mst (.m_clk_i(m_clk), .line_i(line), .scl_o(scl), .sda_o(m_sda));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] sel(input logic rw);
    return {DEV, 3'h0, rw};
  endfunction : sel
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] b, input logic exp, input string what);
    logic a;
    i_mst.wbyte(b, a);
    chk(what, {7'h0, exp}, {7'h0, a});
  endtask : wr
  task automatic busy_is(input logic exp, input string what);
    repeat (2) @(posedge m_clk);
    chk(what, {7'h0, exp}, {7'h0, busy});
  endtask : busy_is
  task automatic rd(input logic [15:0] a, input logic [7:0] exp [$], input string what);
    logic [7:0] d;
    i_mst.start();
    wr(sel(1'b0), 1'b1, "dummy write select");
    wr(a[15:8], 1'b1, "read address high");
    wr(a[7:0], 1'b1, "read address low");
    i_mst.start();
    wr(sel(1'b1), 1'b1, "read select");
    foreach (exp[i]) begin
      i_mst.rbyte(i == exp.size() - 1, d);
      chk(what, exp[i], d);
    end
    i_mst.stop();
  endtask : rd
  task automatic cur(input logic [7:0] exp);
    logic [7:0] d;
    i_mst.start();
    wr(sel(1'b1), 1'b1, "current read select");
    i_mst.rbyte(1'b1, d);
    chk("current read data", exp, d);
    i_mst.stop();
  endtask : cur
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_select();
    logic [7:0] bad [3] = '{{~DEV, 3'h0, 1'b0}, {DEV, 3'h1, 1'b0}, {DEV, 3'h4, 1'b1}};
    foreach (bad[i]) begin
      i_mst.start();
      wr(bad[i], 1'b0, "foreign select");
      wr(8'h00, 1'b0, "byte after mismatch");
      i_mst.stop();
    end
    busy_is(1'b0, "write cycle after mismatch");
  endtask : t_select
  task automatic t_page();
    logic [7:0] pg [3] = '{8'ha1, 8'hb2, 8'hc3};
    logic       ok;
    i_mst.start();
    wr(sel(1'b0), 1'b1, "write select");
    wr(8'h80, 1'b1, "address high");
    wr(8'h7e, 1'b1, "address low");
    foreach (pg[i]) wr(pg[i], 1'b1, "page data");
    i_mst.stop();
    busy_is(1'b1, "write cycle start");
    i_mst.start();
    wr(sel(1'b0), 1'b0, "poll while busy");
    ok = 1'b0;
    for (int n = 0; n < 8 && !ok; n++) begin
      i_mst.start();
      i_mst.wbyte(sel(1'b0), ok);
    end
    chk("poll after write", 8'h01, {7'h0, ok});
    i_mst.stop();
    busy_is(1'b0, "stop without data");
    rd(16'h007e, '{8'ha1}, "random read");
    cur(8'hb2);
    rd(16'h807e, '{8'ha1, 8'hb2}, "sequential read");
    rd(16'h0040, '{8'hc3}, "row wrap");
  endtask : t_page
  task automatic t_inhibit();
    @(negedge sys_clk_i);
    inhibit = 1'b1;
    i_mst.start();
    wr(sel(1'b0), 1'b1, "inhibited select");
    wr(8'h00, 1'b1, "inhibited address high");
    @(negedge sys_clk_i);
    inhibit = 1'b0;
    wr(8'h40, 1'b1, "address low");
    wr(8'h5a, 1'b0, "inhibited data");
    i_mst.stop();
    busy_is(1'b0, "inhibited write cycle");
    @(negedge sys_clk_i);
    inhibit = 1'b1;
    rd(16'h0040, '{8'hc3}, "read under inhibit");
    @(negedge sys_clk_i);
    inhibit = 1'b0;
  endtask : t_inhibit
  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  initial begin
    repeat (16) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    reset_i = 1'b0;
    busy_is(1'b0, "busy after reset");
    t_select();
    t_page();
    t_inhibit();
    results();
  end
  // long enough for all scenarios at the slow serial rate
  initial begin
    #400_000;
    n_errors++;
    $display("unexpected run time: expected finish, seen hang");
    results();
  end
endmodule : tb
